// >>> add_pkg.sv
/*
 * Constants and types for the add-family decode and execute block:
 * vectors, instruction layout, register map and status bits.
 * Assumes a 32-bit instruction word with bit 0 as its top bit.
 */
`default_nettype none
package add_pkg;

    // -----------------------------------------------------------------
    // vector addresses
    // -----------------------------------------------------------------
    localparam logic [31:0] VEC_RESET    = 32'h0000_0000;
    localparam logic [31:0] VEC_USER_EXC = 32'h0000_0008;
    localparam logic [31:0] VEC_IRQ      = 32'h0000_0010;
    localparam logic [31:0] VEC_BREAK    = 32'h0000_0018;
    localparam logic [31:0] VEC_HW_EXC   = 32'h0000_0020;
    localparam logic [31:0] RSV_LO       = 32'h0000_0028;
    localparam logic [31:0] RSV_HI       = 32'h0000_004F;
    localparam logic [31:0] PC_STEP      = 32'h0000_0004;

    // -----------------------------------------------------------------
    // instruction layout, listed from bit 0 (msb) downward
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  opc_top;
        logic        typeb;
        logic        keep;
        logic        cin;
        logic        opc_low;
        logic [4:0]  rd;
        logic [4:0]  ra;
        logic [15:0] low;
    } instr_t;

    typedef struct packed {
        logic [4:0]  rb;
        logic [10:0] pad;
    } tail_t;

    localparam logic [1:0]  ADD_OPC_TOP  = 2'h0;
    localparam logic        ADD_OPC_LOW  = 1'h0;
    localparam logic [10:0] PAD_ZERO     = 11'h000;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
    localparam logic [4:0]  ZERO_REG     = 5'h00;
    localparam logic [4:0]  IRQ_RET_REG  = 5'h0E;

    typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_SAVE} op_t;

    // -----------------------------------------------------------------
    // register map (word index) and fields
    // -----------------------------------------------------------------
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_MASK   = 3'h2;
    localparam logic [2:0] REG_MSW    = 3'h3;
    localparam int CTRL_TRAP_OPT = 0;
    localparam int CTRL_ILL_EN   = 1;
    localparam int ST_ILL  = 0;
    localparam int ST_IRQ  = 1;
    localparam int ST_HWE  = 2;
    localparam int ST_BRK  = 3;
    localparam int ST_UEXC = 4;
    localparam int ST_W    = 5;
    localparam int MSW_CARRY_BIT = 0;
    localparam logic [1:0]      CTRL_RST = 2'h0;
    localparam logic [ST_W-1:0] ST_RST   = 5'h00;

endpackage : add_pkg
`default_nettype wire

// >>> rf_if.sv
/*
 * Register file port bundle between the execute logic and the bank.
 * Assumes one write port and two registered read ports.
 */
`timescale 1ns/1ps
`default_nettype none
interface rf_if;
    logic [4:0]  raddr_a;
    logic [4:0]  raddr_b;
    logic        we;
    logic [4:0]  waddr;
    logic [31:0] wdata;
    logic [31:0] rdata_a;
    logic [31:0] rdata_b;
    modport core (output raddr_a, output raddr_b, output we, output waddr,
                  output wdata, input rdata_a, input rdata_b);
    modport mem  (input raddr_a, input raddr_b, input we, input waddr,
                  input wdata, output rdata_a, output rdata_b);
endinterface : rf_if
`default_nettype wire

// >>> reg_bank.sv
/*
 * Thirty-two general registers with registered read data.
 * Assumes the caller forwards a write made in the same cycle as a read.
 */
`timescale 1ns/1ps
`default_nettype none
module reg_bank (
    input  wire logic mclk,
    input  wire logic rst_n,
    rf_if.mem         rf
);
    logic [31:0] mem_q [32];

    // -----------------------------------------------------------------
    // storage; register zero is never written
    // -----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rf.we && rf.waddr != add_pkg::ZERO_REG) begin
            mem_q[rf.waddr] <= rf.wdata;
        end
    end

    // read before write; zero register forced to zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rf.rdata_a <= 32'h0000_0000;
            rf.rdata_b <= 32'h0000_0000;
        end else begin
            rf.rdata_a <= (rf.raddr_a == add_pkg::ZERO_REG) ?
                          32'h0000_0000 : mem_q[rf.raddr_a];
            rf.rdata_b <= (rf.raddr_b == add_pkg::ZERO_REG) ?
                          32'h0000_0000 : mem_q[rf.raddr_b];
        end
    end
endmodule : reg_bank
`default_nettype wire

// >>> add_core.sv
/*
 * Add-family decode and execute with vectoring and an Avalon-MM slave.
 * Assumes fetch presents one instruction word per valid cycle and
 * follows pc_ff after every redirect pulse.
 */
// Design decisions made here: register access over Avalon-MM and the register addresses.
// Function
// - reset fetches at 0x0, user exception at 0x8, interrupt at 0x10
// - break jumps to 0x18, hardware exception 0x20; 0x28-0x4F never a vector
// - register form: opcode, destination, source a, source b, zero tail
// - immediate form: same first three fields, 16-bit immediate at bottom
// - register add writes source a plus source b to destination
// - bit 3 set keeps the carry flag unchanged
// - bit 3 clear loads carry out into the carry flag
// - bit 4 set adds the current carry flag into the sum
// - four register variants from bits 3 and 4
// - immediate add sign-extends immediate, adds source a, writes destination
// - immediate variants use bits 3 and 4 the same way
// - all-zero word traps when the option and illegal traps are on
// - 32 registers, register zero reads zero, interrupt return in 14
`timescale 1ns/1ps
`default_nettype none
module add_core (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr_word,
    input  wire logic        user_exc_in,
    input  wire logic        irq_in,
    input  wire logic        brk_in,
    input  wire logic        hw_exc_in,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata_ff,
    output logic             avs_waitrequest_ff,
    output logic             irq_out_ff,
    output logic [31:0]      pc_ff,
    output logic             redirect_ff,
    output logic             wb_valid_ff,
    output logic [4:0]       wb_addr_ff,
    output logic [31:0]      wb_data_ff,
    output logic             arith_flag_ff
);
    rf_if rf ();

    reg_bank u_bank (
        .mclk  (mclk),
        .rst_n (rst_n),
        .rf    (rf.mem)
    );

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    add_pkg::instr_t ins;
    add_pkg::tail_t  tail;
    logic            is_add;
    logic            zero_trap;
    logic [1:0]      ctrl_ff;
    logic [add_pkg::ST_W-1:0] status_ff;
    logic [add_pkg::ST_W-1:0] mask_ff;

    // packed struct puts bit 0 at the top of the word
    assign ins  = add_pkg::instr_t'(instr_word);
    assign tail = add_pkg::tail_t'(ins.low);

    // type a needs the zero tail; type b has none
    assign is_add = ins.opc_top == add_pkg::ADD_OPC_TOP
                 && ins.opc_low == add_pkg::ADD_OPC_LOW
                 && (ins.typeb || tail.pad == add_pkg::PAD_ZERO);

    assign zero_trap = instr_valid && instr_word == add_pkg::ZERO_WORD
                    && ctrl_ff[add_pkg::CTRL_TRAP_OPT]
                    && ctrl_ff[add_pkg::CTRL_ILL_EN];

    assign rf.raddr_a = ins.ra;
    assign rf.raddr_b = tail.rb;

    // -----------------------------------------------------------------
    // event priority and vector choice
    // -----------------------------------------------------------------
    logic        take_hw;
    logic        take_brk;
    logic        take_uexc;
    logic        take_irq;
    logic        any_evt;
    logic [31:0] evt_vec;
    logic        issue;

    assign take_hw   = hw_exc_in || zero_trap;
    assign take_brk  = !take_hw && brk_in;
    assign take_uexc = !take_hw && !brk_in && user_exc_in;
    assign take_irq  = !take_hw && !brk_in && !user_exc_in && irq_in;
    assign any_evt   = take_hw || brk_in || user_exc_in || irq_in;
    // an event drops the instruction offered in the same cycle
    assign issue     = instr_valid && !any_evt && is_add;

    always_comb begin
        evt_vec = add_pkg::VEC_IRQ;
        if (take_hw) begin
            evt_vec = add_pkg::VEC_HW_EXC;
        end else if (take_brk) begin
            evt_vec = add_pkg::VEC_BREAK;
        end else if (take_uexc) begin
            evt_vec = add_pkg::VEC_USER_EXC;
        end
    end

    // fetch address; reset starts at the reset vector
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff       <= add_pkg::VEC_RESET;
            redirect_ff <= 1'h0;
        end else begin
            redirect_ff <= any_evt;
            if (any_evt) begin
                pc_ff <= evt_vec;
            end else if (instr_valid) begin
                pc_ff <= pc_ff + add_pkg::PC_STEP;
            end
        end
    end

    // -----------------------------------------------------------------
    // execute stage registers
    // -----------------------------------------------------------------
    add_pkg::op_t s1_op_ff;
    logic [4:0]   s1_rd_ff;
    logic [4:0]   s1_ra_ff;
    logic [4:0]   s1_rb_ff;
    logic         s1_typeb_ff;
    logic         s1_keep_ff;
    logic         s1_cin_ff;
    logic [15:0]  s1_imm_ff;
    logic [31:0]  s1_save_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_op_ff    <= add_pkg::OP_NONE;
            s1_rd_ff    <= add_pkg::ZERO_REG;
            s1_ra_ff    <= add_pkg::ZERO_REG;
            s1_rb_ff    <= add_pkg::ZERO_REG;
            s1_typeb_ff <= 1'h0;
            s1_keep_ff  <= 1'h0;
            s1_cin_ff   <= 1'h0;
            s1_imm_ff   <= 16'h0000;
            s1_save_ff  <= 32'h0000_0000;
        end else begin
            s1_op_ff    <= add_pkg::OP_NONE;
            s1_ra_ff    <= ins.ra;
            s1_rb_ff    <= tail.rb;
            s1_typeb_ff <= ins.typeb;
            s1_keep_ff  <= ins.keep;
            s1_cin_ff   <= ins.cin;
            s1_imm_ff   <= ins.low;
            s1_rd_ff    <= ins.rd;
            if (take_irq) begin
                // return address is the dropped instruction
                s1_op_ff   <= add_pkg::OP_SAVE;
                s1_rd_ff   <= add_pkg::IRQ_RET_REG;
                s1_save_ff <= pc_ff;
            end else if (issue) begin
                s1_op_ff <= add_pkg::OP_ADD;
            end
        end
    end

    // -----------------------------------------------------------------
    // operands with forwarding of last write
    // -----------------------------------------------------------------
    logic [31:0] op_a;
    logic [31:0] op_b;
    logic [31:0] imm_ext;
    logic        cin_v;
    logic [32:0] sum33;
    logic        exec_cout;
    logic        exec_we;
    logic [31:0] exec_wdata;

    // bank read misses a write made on the same edge, so bypass it
    assign op_a = (wb_valid_ff && wb_addr_ff == s1_ra_ff) ?
                  wb_data_ff : rf.rdata_a;
    assign imm_ext = 32'($signed(s1_imm_ff));
    assign op_b = s1_typeb_ff ? imm_ext :
                  (wb_valid_ff && wb_addr_ff == s1_rb_ff) ?
                  wb_data_ff : rf.rdata_b;
    assign cin_v = s1_cin_ff && arith_flag_ff;
    assign sum33 = {1'h0, op_a} + {1'h0, op_b}
                 + {32'h0000_0000, cin_v};
    assign exec_cout = sum33[32];

    // writes to register zero are dropped, so never forwarded
    assign exec_we = (s1_op_ff == add_pkg::OP_SAVE)
                  || (s1_op_ff == add_pkg::OP_ADD
                      && s1_rd_ff != add_pkg::ZERO_REG);
    assign exec_wdata = (s1_op_ff == add_pkg::OP_SAVE) ?
                        s1_save_ff : sum33[31:0];

    assign rf.we    = exec_we;
    assign rf.waddr = s1_rd_ff;
    assign rf.wdata = exec_wdata;

    // writeback copy, also the forward source
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_valid_ff <= 1'h0;
            wb_addr_ff  <= add_pkg::ZERO_REG;
            wb_data_ff  <= 32'h0000_0000;
        end else begin
            wb_valid_ff <= exec_we;
            wb_addr_ff  <= s1_rd_ff;
            wb_data_ff  <= exec_wdata;
        end
    end

    // carry flag of the machine state word
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arith_flag_ff <= 1'h0;
        end else if (s1_op_ff == add_pkg::OP_ADD && !s1_keep_ff) begin
            arith_flag_ff <= exec_cout;
        end
    end

    // -----------------------------------------------------------------
    // avalon slave: one wait cycle per access
    // -----------------------------------------------------------------
    logic                     acc;
    logic                     wr_hit;
    logic [add_pkg::ST_W-1:0] st_set;
    logic [add_pkg::ST_W-1:0] st_clr;

    assign acc    = (avs_read || avs_write) && !avs_waitrequest_ff;
    assign wr_hit = acc && avs_write && avs_byteenable[0];

    // waitrequest drops for the cycle after a request is seen
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest_ff <= 1'h1;
        end else begin
            avs_waitrequest_ff <= !((avs_read || avs_write)
                                    && avs_waitrequest_ff);
        end
    end

    always_comb begin
        st_set = add_pkg::ST_RST;
        st_set[add_pkg::ST_ILL]  = zero_trap;
        st_set[add_pkg::ST_HWE]  = hw_exc_in;
        st_set[add_pkg::ST_BRK]  = take_brk;
        st_set[add_pkg::ST_UEXC] = take_uexc;
        st_set[add_pkg::ST_IRQ]  = take_irq;
    end

    assign st_clr = (wr_hit && avs_address == add_pkg::REG_STATUS) ?
                    avs_writedata[add_pkg::ST_W-1:0] : add_pkg::ST_RST;

    // sticky status; a new event beats a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= add_pkg::ST_RST;
        end else begin
            status_ff <= (status_ff & ~st_clr) | st_set;
        end
    end

    // control and mask writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= add_pkg::CTRL_RST;
            mask_ff <= add_pkg::ST_RST;
        end else if (wr_hit) begin
            if (avs_address == add_pkg::REG_CTRL) begin
                ctrl_ff <= avs_writedata[1:0];
            end
            if (avs_address == add_pkg::REG_MASK) begin
                mask_ff <= avs_writedata[add_pkg::ST_W-1:0];
            end
        end
    end

    // read data; unmapped words read zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_ff <= 32'h0000_0000;
        end else begin
            avs_readdata_ff <= 32'h0000_0000;
            if (avs_read && avs_waitrequest_ff) begin
                unique case (avs_address)
                    add_pkg::REG_CTRL:   avs_readdata_ff[1:0] <= ctrl_ff;
                    add_pkg::REG_STATUS: begin
                        avs_readdata_ff[add_pkg::ST_W-1:0] <= status_ff;
                    end
                    add_pkg::REG_MASK: begin
                        avs_readdata_ff[add_pkg::ST_W-1:0] <= mask_ff;
                    end
                    add_pkg::REG_MSW: begin
                        avs_readdata_ff[add_pkg::MSW_CARRY_BIT] <= arith_flag_ff;
                    end
                    default: avs_readdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_out_ff <= 1'h0;
        end else begin
            irq_out_ff <= |(status_ff & mask_ff);
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    logic moved_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            moved_ff <= 1'h0;
        end else if (any_evt || instr_valid) begin
            moved_ff <= 1'h1;
        end
    end

    sequence s_issue;
        issue && ins.rd != add_pkg::ZERO_REG;
    endsequence

    sequence s_irq;
        take_irq;
    endsequence

    property p_reset_vec;
        @(posedge mclk) disable iff (!rst_n)
        !moved_ff |-> pc_ff == add_pkg::VEC_RESET;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("fetch did not start at reset vector");

    property p_irq_vec;
        @(posedge mclk) disable iff (!rst_n)
        s_irq |=> redirect_ff && pc_ff == add_pkg::VEC_IRQ;
    endproperty
    a_irq_vec: assert property (p_irq_vec)
        else $error("interrupt vector wrong");

    property p_uexc_vec;
        @(posedge mclk) disable iff (!rst_n)
        take_uexc |=> pc_ff == add_pkg::VEC_USER_EXC;
    endproperty
    a_uexc_vec: assert property (p_uexc_vec)
        else $error("user exception vector wrong");

    property p_brk_vec;
        @(posedge mclk) disable iff (!rst_n)
        take_brk |=> pc_ff == add_pkg::VEC_BREAK;
    endproperty
    a_brk_vec: assert property (p_brk_vec)
        else $error("break vector wrong");

    property p_rsv_gap;
        @(posedge mclk) disable iff (!rst_n)
        redirect_ff |-> !(pc_ff inside {[add_pkg::RSV_LO:add_pkg::RSV_HI]});
    endproperty
    a_rsv_gap: assert property (p_rsv_gap)
        else $error("redirect into reserved range");

    property p_add_wb;
        @(posedge mclk) disable iff (!rst_n)
        s_issue |-> ##2 wb_valid_ff && wb_addr_ff == $past(ins.rd, 2);
    endproperty
    a_add_wb: assert property (p_add_wb)
        else $error("add result not written two cycles on");

    property p_keep;
        @(posedge mclk) disable iff (!rst_n)
        s1_op_ff == add_pkg::OP_ADD && s1_keep_ff |=> $stable(arith_flag_ff);
    endproperty
    a_keep: assert property (p_keep)
        else $error("kept carry changed");

    property p_carry_upd;
        @(posedge mclk) disable iff (!rst_n)
        s1_op_ff == add_pkg::OP_ADD && !s1_keep_ff
        |=> arith_flag_ff == $past(exec_cout);
    endproperty
    a_carry_upd: assert property (p_carry_upd)
        else $error("carry flag not loaded");

    property p_cin_sum;
        @(posedge mclk) disable iff (!rst_n)
        exec_we && s1_op_ff == add_pkg::OP_ADD && s1_cin_ff && arith_flag_ff
        |=> wb_data_ff == $past(op_a) + $past(op_b) + 32'h0000_0001;
    endproperty
    a_cin_sum: assert property (p_cin_sum)
        else $error("carry-in not added");

    property p_sext;
        @(posedge mclk) disable iff (!rst_n)
        s1_typeb_ff |-> op_b[31:16] == {16{s1_imm_ff[15]}};
    endproperty
    a_sext: assert property (p_sext)
        else $error("immediate not sign-extended");

    property p_zero_trap;
        @(posedge mclk) disable iff (!rst_n)
        zero_trap |=> pc_ff == add_pkg::VEC_HW_EXC
                      && status_ff[add_pkg::ST_ILL] ##1 !wb_valid_ff;
    endproperty
    a_zero_trap: assert property (p_zero_trap)
        else $error("zero word not trapped");

    property p_irq_save;
        @(posedge mclk) disable iff (!rst_n)
        s_irq |-> ##2 wb_valid_ff && wb_addr_ff == add_pkg::IRQ_RET_REG
                  && wb_data_ff == $past(pc_ff, 2);
    endproperty
    a_irq_save: assert property (p_irq_save)
        else $error("interrupt return not saved");

    property p_no_zero_wr;
        @(posedge mclk) disable iff (!rst_n)
        wb_valid_ff |-> wb_addr_ff != add_pkg::ZERO_REG;
    endproperty
    a_no_zero_wr: assert property (p_no_zero_wr)
        else $error("register zero written");

endmodule : add_core
`default_nettype wire

// >>> add_fetch.sv
/* fetch stage model: offers one instruction word per call to issue, two per call to issue_pair.
   assumes the caller stands just past a rising edge of mclk. */
`timescale 1ns/1ps
`default_nettype none
module add_fetch (
    input  wire logic       mclk,
    output var logic        instr_valid,
    output var logic [31:0] instr_word
);
    initial begin
        instr_valid = 1'b0;
        instr_word  = 32'hA5A5_5A5A;
    end
    // word stands one cycle, then is inverted so a stale word never matches
    task automatic issue(input logic [31:0] w);
        instr_valid <= 1'b1;
        instr_word  <= w;
        @(posedge mclk);
        instr_valid <= 1'b0;
        instr_word  <= ~w;
    endtask : issue
    // two words on consecutive edges, so the second needs the forward path
    task automatic issue_pair(input logic [31:0] w1, input logic [31:0] w2);
        instr_valid <= 1'b1;
        instr_word  <= w1;
        @(posedge mclk);
        instr_word  <= w2;
        @(posedge mclk);
        instr_valid <= 1'b0;
        instr_word  <= ~w2;
    endtask : issue_pair
endmodule : add_fetch
`default_nettype wire

// >>> tb_add_family_decode_and_vectors.sv
/* bench for add_core: add variants, zero word trap, vectors, status.
   assumes add_fetch as fetch stage and a 10 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_add_family_decode_and_vectors;
    logic        mclk  = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  evt   = 4'h0;
    logic [2:0]  adr   = 3'h0;
    logic        rd    = 1'b0;
    logic        wr    = 1'b0;
    logic [31:0] wd    = 32'h0;
    logic [31:0] rdata, pc, wbd, iw, q, p;
    logic        waitr, irq, redir, wbv, flag, iv;
    logic [4:0]  wba;
    int          n_fail  = 0;
    int          checked = 0;
    int          cyc     = 0;
    always #50 mclk = ~mclk;
    add_fetch fetch (.mclk(mclk), .instr_valid(iv), .instr_word(iw));
    add_core dut (.mclk(mclk), .rst_n(rst_n), .instr_valid(iv), .instr_word(iw),
        .user_exc_in(evt[0]), .irq_in(evt[1]), .brk_in(evt[2]), .hw_exc_in(evt[3]),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hF), .avs_readdata_ff(rdata), .avs_waitrequest_ff(waitr),
        .irq_out_ff(irq), .pc_ff(pc), .redirect_ff(redir), .wb_valid_ff(wbv),
        .wb_addr_ff(wba), .wb_data_ff(wbd), .arith_flag_ff(flag));
    task automatic end_of_test;
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // hang guard, far above the seventy or so cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // avalon access: held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk);
        rd  <= ~w;
        wr  <= w;
        adr <= a;
        wd  <= d;
        do @(posedge mclk); while (waitr !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    function automatic logic [31:0] ins(input logic [2:0] ikc, input logic [4:0] d,
                                        input logic [4:0] a, input logic [15:0] lo);
        return {2'b00, ikc, 1'b0, d, a, lo};
    endfunction : ins
    // one add, then its write-back and carry; latency polled, not assumed
    task automatic op(input logic [31:0] w, input logic [4:0] a, input logic [31:0] d,
                      input logic c);
        fetch.issue(w);
        repeat (3) begin
            #1;
            if (wbv === 1'b1) break;
            @(posedge mclk);
        end
        chk(32'(wbv), 32'h1);
        chk(32'(wba), 32'(a));
        chk(wbd, d);
        chk(32'(flag), 32'(c));
        @(posedge mclk);
    endtask : op
    task automatic t_adds;
        op(ins(3'b100, 5'h01, 5'h00, 16'hFFFF), 5'h01, 32'hFFFF_FFFF, 1'b0);
        op(ins(3'b100, 5'h02, 5'h00, 16'h0001), 5'h02, 32'h0000_0001, 1'b0);
        op(ins(3'b000, 5'h03, 5'h01, 16'h1000), 5'h03, 32'h0000_0000, 1'b1);
        op(ins(3'b010, 5'h04, 5'h02, 16'h1000), 5'h04, 32'h0000_0002, 1'b1);
        op(ins(3'b111, 5'h06, 5'h01, 16'h0001), 5'h06, 32'h0000_0001, 1'b1);
        op(ins(3'b001, 5'h05, 5'h02, 16'h1000), 5'h05, 32'h0000_0003, 1'b0);
        op(ins(3'b101, 5'h07, 5'h01, 16'h0002), 5'h07, 32'h0000_0001, 1'b1);
        bus(1'b0, 3'h3, 32'h0);
        chk(q, 32'h0000_0001);
    endtask : t_adds
    // back-to-back pair: second reads the first's result and fresh carry
    task automatic t_fwd;
        fetch.issue_pair(ins(3'b100, 5'h08, 5'h02, 16'h0005),
                         ins(3'b001, 5'h09, 5'h08, 16'h4000));
        #1;
        chk(32'(wbv), 32'h1);
        chk(32'(wba), 32'h8);
        chk(wbd, 32'h0000_0006);
        @(posedge mclk);
        #1;
        chk(32'(wba), 32'h9);
        chk(wbd, 32'h0000_000C);
        chk(32'(flag), 32'h0);
        @(posedge mclk);
    endtask : t_fwd
    task automatic t_zero;
        p = pc;
        fetch.issue(32'h0000_0000);
        #1;
        chk(pc, p + 32'h4);
        bus(1'b1, 3'h0, 32'h0000_0003);
        fetch.issue(32'h0000_0000);
        #1;
        chk({31'h0, redir}, 32'h1);
        chk(pc, 32'h0000_0020);
        @(posedge mclk);
    endtask : t_zero
    task automatic ev(input int i, input logic [31:0] v);
        p = pc;
        evt[i] <= 1'b1;
        @(posedge mclk);
        evt <= 4'h0;
        #1;
        chk(pc, v);
        chk({31'h0, redir}, 32'h1);
        @(posedge mclk);
        #1;
        if (i == 1) begin
            chk({27'h0, wba}, 32'h0000_000E);
            chk(wbd, p);
        end
        @(posedge mclk);
    endtask : ev
    task automatic t_events;
        ev(0, 32'h0000_0008);
        ev(1, 32'h0000_0010);
        ev(2, 32'h0000_0018);
        ev(3, 32'h0000_0020);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 3'h2, 32'h0000_001F);
        @(posedge mclk);
        #1;
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, 3'h1, 32'h0);
        chk(q, 32'h0000_001F);
        bus(1'b1, 3'h1, 32'h0000_001F);
        bus(1'b0, 3'h1, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, 3'h5, 32'h0);
        chk(q, 32'h0);
    endtask : t_events
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk(pc, 32'h0000_0000);
        @(posedge mclk);
        t_adds();
        t_fwd();
        t_zero();
        t_events();
        end_of_test();
    end
endmodule : tb_add_family_decode_and_vectors
`default_nettype wire
